// [dual_style_host_bus_port_test.sv]
`timescale 1ns/1ns
module dual_style_host_bus_port_test
    import host_port_pkg::*;
;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic style, sel_n, rd_n, wr_n, dat_oe, ack, ack_oe, irq_out, reg_rd, reg_wr, pol;
    logic reg_ready = 1'h0;
    logic irq_pending = 1'h0;
    logic [ADDR_W-1:0] addr, reg_addr, seen_a;
    logic [DATA_W-1:0] dat_in, dat_out, reg_wdata, seen_d;
    logic [DATA_W-1:0] reg_rdata = 8'h00;
    int errors = 0;
    int checks = 0;
    int cyc = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    always #25 mclk = ~mclk;
    host_port u_host_port(.mclk(mclk), .rst(rst), .bus_style_select(style), .sel_n(sel_n),
        .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .dat_in(dat_in), .dat_out(dat_out),
        .dat_oe(dat_oe), .transfer_ack(ack), .transfer_ack_oe(ack_oe), .irq_out(irq_out),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_rdata(reg_rdata), .reg_ready(reg_ready), .irq_pending(irq_pending),
        .irq_polarity_invert(pol));
    host_cpu_model u_host_cpu_model(.mclk(mclk), .dat_out(dat_out), .dat_oe(dat_oe),
        .transfer_ack(ack), .transfer_ack_oe(ack_oe), .bus_style_select(style),
        .sel_n(sel_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .dat_in(dat_in));
    task automatic end_sim();
        if (errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // sampled mid-cycle, away from the edge that launches the pulses
    always @(negedge mclk) begin
        if (reg_rd === 1'h1) begin
            rd_cnt++;
            seen_a = reg_addr;
        end
        if (reg_wr === 1'h1) begin
            wr_cnt++;
            seen_a = reg_addr;
            seen_d = reg_wdata;
        end
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic t_irq(input logic base);
        for (int p = 0; p < 2; p++) begin
            @(negedge mclk);
            irq_pending = p[0];
            repeat (2) @(negedge mclk);
            check("irq_out", 12'(base ^ p[0]), 12'(irq_out));
        end
    endtask
    task automatic t_write(input logic [11:0] a, input logic [7:0] d, input logic exp_pol);
        int w0;
        logic [7:0] q;
        logic ok;
        w0 = wr_cnt;
        u_host_cpu_model.xfer(1'h0, a, d, q, ok);
        check("write ack", 12'h1, 12'(ok));
        check("write count", 12'(w0 + 1), 12'(wr_cnt));
        check("write addr", a, seen_a);
        check("write data", 12'(d), 12'(seen_d));
        check("polarity", 12'(exp_pol), 12'(pol));
    endtask
    task automatic t_read(input logic [11:0] a, input logic [7:0] v, input logic busy);
        int r0;
        logic [7:0] q;
        logic ok;
        r0 = rd_cnt;
        reg_rdata = v;
        reg_ready = !busy;
        fork
            u_host_cpu_model.xfer(1'h1, a, v, q, ok);
            if (busy) begin
                repeat (8) @(negedge mclk);
                check("ack while busy", 12'h2, 12'({ack_oe, ack}));
                reg_ready = 1'h1;
            end
        join
        check("read ack", 12'h1, 12'(ok));
        check("read data", 12'(v), 12'(q));
        check("read count", 12'(r0 + 1), 12'(rd_cnt));
        check("read addr", a, seen_a);
        check("released", 12'h0, 12'({ack_oe, dat_oe}));
    endtask
    task automatic t_stray();
        int r0;
        int w0;
        r0 = rd_cnt;
        w0 = wr_cnt;
        u_host_cpu_model.stray();
        check("no access", 12'(r0 + w0), 12'(rd_cnt + wr_cnt));
        check("ack idle", 12'h0, 12'(ack_oe));
    endtask
    task automatic t_reset();
        t_write(GLOBAL_CTRL_ADDR, 8'h10, 1'h1);
        @(negedge mclk);
        rst = 1'h1;
        @(negedge mclk);
        check("reset outputs", 12'h01, 12'({pol, ack_oe, dat_oe, irq_out, ack}));
        // mid-run reset held one cycle past the minimum length
        repeat (RESET_MIN_CYCLES) @(negedge mclk);
        rst = 1'h0;
        repeat (4) @(negedge mclk);
        t_read(12'h0aa, 8'h5a, 1'h0);
    endtask
    // clock runs before and during reset
    initial begin
        repeat (5) @(negedge mclk);
        rst = 1'h0;
        repeat (2) @(negedge mclk);
        u_host_cpu_model.set_style(1'h0);
        t_irq(1'h0);
        t_read(12'h123, 8'ha5, 1'h1);
        t_write(GLOBAL_CTRL_ADDR, 8'h10, 1'h1);
        t_irq(1'h1);
        t_stray();
        u_host_cpu_model.set_style(1'h1);
        t_irq(1'h0);
        t_read(12'hfff, 8'h3c, 1'h0);
        t_write(GLOBAL_CTRL_ADDR, 8'hef, 1'h0);
        t_irq(1'h1);
        t_write(12'h000, 8'h10, 1'h0);
        t_reset();
        end_sim();
    end
endmodule

// [host_cpu_model.sv]
`timescale 1ns/1ns
module host_cpu_model
    import host_port_pkg::*;
(
    input wire logic mclk,
    input wire logic [DATA_W-1:0] dat_out,
    input wire logic dat_oe,
    input wire logic transfer_ack,
    input wire logic transfer_ack_oe,
    output logic bus_style_select,
    output logic sel_n,
    output logic rd_n,
    output logic wr_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dat_in
);
    logic drv;
    logic [DATA_W-1:0] val;
    // no pull-up on the data lines: a released bus shows the inverse value
    assign dat_in = dat_oe ? dat_out : (drv ? val : ~val);
    initial begin
        bus_style_select = 1'h0;
        sel_n = 1'h1;
        rd_n = 1'h1;
        wr_n = 1'h1;
        addr = 12'h000;
        drv = 1'h0;
        val = 8'h00;
    end
    // style pin held static between transfers
    task automatic set_style(input logic s);
        @(negedge mclk);
        bus_style_select = s;
        repeat (4) @(negedge mclk);
    endtask
    task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q, output logic ok);
        int n;
        @(negedge mclk);
        addr = a;
        val = d;
        drv = !rd;
        // select held for the whole transfer
        sel_n = 1'h0;
        rd_n = bus_style_select ? rd : !rd;
        wr_n = bus_style_select ? 1'h1 : rd;
        ok = 1'h0;
        q = 8'h00;
        // wait states until completion level
        // looked at mid-cycle: flop outputs are settled and stand to the next edge
        for (n = 0; n < 60 && !ok; n++) begin
            @(negedge mclk);
            if (transfer_ack_oe === 1'h1 && transfer_ack === !bus_style_select) begin
                ok = 1'h1;
                q = dat_in;
            end
        end
        @(negedge mclk);
        sel_n = 1'h1;
        rd_n = 1'h1;
        wr_n = 1'h1;
        drv = 1'h0;
        addr = ~a;
        repeat (4) @(negedge mclk);
    endtask
    task automatic stray();
        @(negedge mclk);
        rd_n = 1'h0;
        wr_n = 1'h0;
        repeat (6) @(negedge mclk);
        rd_n = 1'h1;
        wr_n = 1'h1;
        repeat (4) @(negedge mclk);
    endtask
endmodule

// [host_port.sv]
`timescale 1ns/1ns
// Operation
// - separate-strobe style: ack driven high when the location can complete.
// - separate-strobe style: ack low while busy; host waits until it rises.
// - combined style read: ack goes low only with valid data on the bus.
// - combined style write: ack goes low to confirm the data was taken.
// - combined style: ack released to high impedance after its low pulse.
// - separate-strobe style, default polarity: interrupt request shown as high.
// - combined style, default polarity: interrupt request shown as low.
// - polarity invert bit 4 of control register 006h flips interrupt sense.
// - device enters its reset state while reset is asserted.
// - state machines and counters run on the system clock.
// - register transfers happen only while chip select is held low.
module host_port
    import host_port_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic bus_style_select,
    input wire logic sel_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dat_in,
    output logic [DATA_W-1:0] dat_out,
    output logic dat_oe,
    output logic transfer_ack,
    output logic transfer_ack_oe,
    output logic irq_out,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] reg_wdata,
    output logic reg_rd,
    output logic reg_wr,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic reg_ready,
    input wire logic irq_pending,
    output logic irq_polarity_invert
);

    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] sync_nxt;

    port_state_t state_r;
    port_state_t state_nxt;
    logic is_rd_r;
    logic is_rd_nxt;
    logic [ADDR_W-1:0] reg_addr_r;
    logic [ADDR_W-1:0] reg_addr_nxt;
    logic [DATA_W-1:0] reg_wdata_r;
    logic [DATA_W-1:0] reg_wdata_nxt;
    logic reg_rd_r;
    logic reg_rd_nxt;
    logic reg_wr_r;
    logic reg_wr_nxt;
    logic [DATA_W-1:0] dat_out_r;
    logic [DATA_W-1:0] dat_out_nxt;
    logic dat_oe_r;
    logic dat_oe_nxt;
    logic ack_out_r;
    logic ack_out_nxt;
    logic ack_oe_r;
    logic ack_oe_nxt;
    logic irq_out_r;
    logic irq_out_nxt;
    logic irq_pol_r;
    logic irq_pol_nxt;

    logic sel_w;
    logic style_m_w;
    logic rd_req_w;
    logic wr_req_w;
    logic xfer_end_w;

    always_comb begin
        sync_nxt = {dat_in, addr, bus_style_select, wr_n, rd_n, sel_n};
    end

    always_comb begin
        sel_w = ~sync2_r[SYNC_SEL];
        style_m_w = sync2_r[SYNC_STYLE];
        // combined style reads on a high read/write line
        if (style_m_w) begin
            rd_req_w = sel_w & sync2_r[SYNC_RD];
            // write strobe not looked at in combined style
            wr_req_w = sel_w & ~sync2_r[SYNC_RD];
        end else begin
            rd_req_w = sel_w & ~sync2_r[SYNC_RD];
            // write strobe low selects a write
            wr_req_w = sel_w & ~sync2_r[SYNC_WR];
        end
        // combined style this reduces to select released
        xfer_end_w = ~(rd_req_w | wr_req_w);
    end

    always_comb begin
        state_nxt = state_r;
        is_rd_nxt = is_rd_r;
        reg_addr_nxt = reg_addr_r;
        reg_wdata_nxt = reg_wdata_r;
        reg_rd_nxt = 1'b0;
        reg_wr_nxt = 1'b0;
        dat_out_nxt = dat_out_r;
        dat_oe_nxt = dat_oe_r;
        ack_out_nxt = ack_out_r;
        ack_oe_nxt = ack_oe_r;
        irq_pol_nxt = irq_pol_r;
        case (state_r)
            ST_IDLE: begin
                ack_oe_nxt = 1'b0;
                dat_oe_nxt = 1'b0;
                if (rd_req_w | wr_req_w) begin
                    state_nxt = ST_WAIT;
                    is_rd_nxt = rd_req_w;
                    reg_addr_nxt = sync2_r[SYNC_ADDR_LSB +: ADDR_W];
                    reg_wdata_nxt = sync2_r[SYNC_DAT_LSB +: DATA_W];
                    reg_rd_nxt = rd_req_w;
                    reg_wr_nxt = ~rd_req_w;
                    ack_oe_nxt = 1'b1;
                    // separate strobes show wait as low
                    ack_out_nxt = style_m_w;
                end
            end
            ST_WAIT: begin
                if (xfer_end_w) begin
                    // host gave up; core access finishes unseen
                    state_nxt = ST_IDLE;
                    ack_oe_nxt = 1'b0;
                    ack_out_nxt = ACK_OUT_RST;
                end else if (reg_ready) begin
                    state_nxt = ST_ACK;
                    // data and ack leave on the same edge
                    if (is_rd_r) begin
                        dat_out_nxt = reg_rdata;
                        dat_oe_nxt = 1'b1;
                    end else if (reg_addr_r == GLOBAL_CTRL_ADDR) begin
                        irq_pol_nxt = reg_wdata_r[IRQ_POL_BIT];
                    end
                    // separate strobes go high on completion
                    ack_out_nxt = ~style_m_w;
                end
            end
            ST_ACK: begin
                if (xfer_end_w) begin
                    state_nxt = ST_IDLE;
                    dat_oe_nxt = 1'b0;
                    // let the line float after the low ack
                    ack_oe_nxt = 1'b0;
                    ack_out_nxt = ACK_OUT_RST;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // separate strobes show a request as high with the polarity bit clear
    // combined style shows a request as low with the polarity bit clear; a set bit inverts both
    always_comb begin
        irq_out_nxt = irq_pending ^ style_m_w ^ irq_pol_r;
    end

    // all state on the one system clock
    // reset forces every flop to its idle value
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            state_r <= ST_IDLE;
            is_rd_r <= 1'b0;
            reg_addr_r <= ADDR_RST;
            reg_wdata_r <= DATA_RST;
            reg_rd_r <= 1'b0;
            reg_wr_r <= 1'b0;
            dat_out_r <= DATA_RST;
            dat_oe_r <= OE_RST;
            ack_out_r <= ACK_OUT_RST;
            ack_oe_r <= OE_RST;
            irq_out_r <= IRQ_OUT_RST;
            irq_pol_r <= IRQ_POL_RST;
        end else begin
            sync1_r <= sync_nxt;
            sync2_r <= sync1_r;
            state_r <= state_nxt;
            is_rd_r <= is_rd_nxt;
            reg_addr_r <= reg_addr_nxt;
            reg_wdata_r <= reg_wdata_nxt;
            reg_rd_r <= reg_rd_nxt;
            reg_wr_r <= reg_wr_nxt;
            dat_out_r <= dat_out_nxt;
            dat_oe_r <= dat_oe_nxt;
            ack_out_r <= ack_out_nxt;
            ack_oe_r <= ack_oe_nxt;
            irq_out_r <= irq_out_nxt;
            irq_pol_r <= irq_pol_nxt;
        end
    end

    assign dat_out = dat_out_r;
    assign dat_oe = dat_oe_r;
    assign transfer_ack = ack_out_r;
    assign transfer_ack_oe = ack_oe_r;
    assign irq_out = irq_out_r;
    assign reg_addr = reg_addr_r;
    assign reg_wdata = reg_wdata_r;
    assign reg_rd = reg_rd_r;
    assign reg_wr = reg_wr_r;
    assign irq_polarity_invert = irq_pol_r;

    // helper terms for the checks below
    logic sep_plain_w;
    logic comb_plain_w;
    logic sep_inv_w;
    logic req_w;
    assign sep_plain_w = ~style_m_w & ~irq_pol_r;
    assign comb_plain_w = style_m_w & ~irq_pol_r;
    assign sep_inv_w = ~style_m_w & irq_pol_r;
    assign req_w = reg_rd_r | reg_wr_r;

    a_req_needs_sel: assert property (
        @(posedge mclk) disable iff (rst) req_w |-> ($past(sel_w) && state_r == ST_WAIT))
        else $error("core request without chip select");

    a_sync_depth: assert property (
        @(posedge mclk) disable iff (rst)
        reg_rd_r && !style_m_w |-> !$past(rd_n, 3) && !$past(sel_n, 3))
        else $error("read issued before strobe passed two flops");

    a_sep_wait_low: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_WAIT && !style_m_w |-> transfer_ack_oe && !transfer_ack)
        else $error("ready not low while access pending");

    a_sep_ready_high: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_WAIT && reg_ready && !xfer_end_w && !style_m_w
        |=> state_r == ST_ACK && transfer_ack && transfer_ack_oe)
        else $error("ready not raised on completion");

    a_comb_rd_data: assert property (
        @(posedge mclk) disable iff (rst)
        style_m_w && transfer_ack_oe && !transfer_ack && is_rd_r
        |-> dat_oe && dat_out == $past(reg_rdata, 1) || $past(state_r) == ST_ACK)
        else $error("read ack low without valid data");

    a_comb_wr_ack: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_WAIT && reg_ready && !xfer_end_w && !is_rd_r && style_m_w
        |=> transfer_ack_oe && !transfer_ack && !dat_oe)
        else $error("write not acknowledged low");

    a_ack_release: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_ACK && xfer_end_w |=> (!transfer_ack_oe && !dat_oe) [*2])
        else $error("ack not released after transfer");

    a_irq_sep_plain: assert property (
        @(posedge mclk) disable iff (rst)
        !$past(rst) && $past(sep_plain_w) |-> irq_out == $past(irq_pending))
        else $error("interrupt not active high");

    a_irq_comb_plain: assert property (
        @(posedge mclk) disable iff (rst)
        // first edge after reset still shows the reset value
        !$past(rst) && $past(comb_plain_w) |-> irq_out == !$past(irq_pending))
        else $error("interrupt not active low");

    a_irq_invert: assert property (
        @(posedge mclk) disable iff (rst)
        !$past(rst) && $past(sep_inv_w) |-> irq_out == !$past(irq_pending))
        else $error("inverted interrupt sense wrong");

    a_reset_quiet: assert property (
        @(posedge mclk) $past(rst) |-> !transfer_ack_oe && !dat_oe && !reg_rd && !reg_wr)
        else $error("outputs active right after reset");

    a_comb_wait_high: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_WAIT && style_m_w |-> transfer_ack_oe && transfer_ack)
        else $error("combined ack low before data valid");

    a_sep_ack_stands: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_ACK && !style_m_w |-> transfer_ack_oe && transfer_ack)
        else $error("ready dropped before transfer end");

    a_idle_released: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_IDLE |-> !transfer_ack_oe && !dat_oe)
        else $error("bus driven while idle");

    a_pol_snoop: assert property (
        @(posedge mclk) disable iff (rst)
        state_r == ST_WAIT && reg_ready && !xfer_end_w && !is_rd_r
        && reg_addr_r == GLOBAL_CTRL_ADDR
        |=> irq_polarity_invert == $past(reg_wdata_r[IRQ_POL_BIT]))
        else $error("polarity bit not taken from control write");

endmodule

// [host_port_pkg.sv]
package host_port_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // core clock period, used only to document timing
    localparam int CORE_CLK_PERIOD_NS = 50;
    localparam int RESET_MIN_CYCLES = 10;

    // bit positions inside the synchroniser vector
    localparam int SYNC_SEL = 0;
    localparam int SYNC_RD = 1;
    localparam int SYNC_WR = 2;
    localparam int SYNC_STYLE = 3;
    localparam int SYNC_ADDR_LSB = 4;
    localparam int SYNC_DAT_LSB = SYNC_ADDR_LSB + ADDR_W;
    localparam int SYNC_W = SYNC_DAT_LSB + DATA_W;

    // global control register and its interrupt polarity bit
    localparam logic [ADDR_W-1:0] GLOBAL_CTRL_ADDR = 12'h006;
    localparam int IRQ_POL_BIT = 4;

    // values after reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 24'hff_ffff;
    localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic ACK_OUT_RST = 1'h1;
    localparam logic OE_RST = 1'h0;
    localparam logic IRQ_OUT_RST = 1'h0;
    localparam logic IRQ_POL_RST = 1'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_ACK
    } port_state_t;

endpackage
